// [afc_pkg.sv]
// constants shared by the auxiliary flag command handler and its helpers
// assumes byte-wide ascii characters and a single system clock
package afc_pkg;
    // frame characters
    localparam logic [7:0] CHAR_WRITE_DLM = 8'h23;
    localparam logic [7:0] CHAR_READ_DLM  = 8'h24;
    localparam logic [7:0] CHAR_CR        = 8'h0D;
    localparam logic [7:0] CHAR_ACK       = 8'h3E;
    localparam logic [7:0] CHAR_NAK       = 8'h3F;
    localparam logic [7:0] CHAR_CODE_0    = 8'h56;
    localparam logic [7:0] CHAR_CODE_1    = 8'h64;

    // hex digit to ascii offsets
    localparam logic [7:0] ASCII_DIGIT_BASE = 8'h30;
    localparam logic [7:0] ASCII_ALPHA_BASE = 8'h37;
    localparam logic [7:0] ASCII_LOWER_BASE = 8'h57;

    // module identity and flag bank
    localparam logic [7:0]  OWN_ADDR   = 8'h01;
    localparam int          NUM_FLAGS  = 16;
    localparam logic [15:0] FLAGS_RST  = 16'h0000;

    // selector field
    localparam logic [3:0]  SEL_DIGITS  = 4'h4;
    localparam logic [15:0] SEL_ALL     = 16'h0000;
    localparam logic [3:0]  SEL_SINGLE  = 4'h1;

    // field lengths in characters
    localparam logic [3:0] ADDR_DIGITS    = 4'h2;
    localparam logic [3:0] CODE_CHARS     = 4'h2;
    localparam logic [3:0] VAL_DIGITS_MAX = 4'h8;
    localparam int         READ_DIGITS    = 7;

    // reply lengths in characters
    localparam int         MSG_BYTES   = 11;
    localparam logic [3:0] LEN_SHORT   = 4'h4;
    localparam logic [3:0] LEN_READ    = 4'hB;
endpackage

// [afc_hex_dec.sv]
// ascii hex digit decoder, purely combinational
// assumes the character is already qualified by its strobe elsewhere
`timescale 1ns/100ps
module afc_hex_dec (
    // character in
    input  wire logic [7:0] char_i,
    // decoded digit
    output logic [3:0]      nibble_o,
    output logic            is_hex_o
);
    logic [7:0] diff;

    always_comb begin
        diff     = 8'h00;
        nibble_o = 4'h0;
        is_hex_o = 1'b0;
        if (char_i >= 8'h30 && char_i <= 8'h39) begin
            diff     = char_i - afc_pkg::ASCII_DIGIT_BASE;
            nibble_o = diff[3:0];
            is_hex_o = 1'b1;
        end else if (char_i >= 8'h41 && char_i <= 8'h46) begin
            diff     = char_i - afc_pkg::ASCII_ALPHA_BASE;
            nibble_o = diff[3:0];
            is_hex_o = 1'b1;
        end else if (char_i >= 8'h61 && char_i <= 8'h66) begin
            // lower case accepted as well, hosts differ here
            diff     = char_i - afc_pkg::ASCII_LOWER_BASE;
            nibble_o = diff[3:0];
            is_hex_o = 1'b1;
        end
    end
endmodule

// [afc_tx.sv]
// reply serialiser: sends a prepared message one character at a time
// assumes the sink takes a character on a clock edge with valid and ready high
`timescale 1ns/100ps
module afc_tx (
    // clock and reset
    input  wire logic                              clk_sys_i,
    input  wire logic                              rst_n_i,
    // message load
    input  wire logic                              start_i,
    input  wire logic [afc_pkg::MSG_BYTES*8-1:0]   msg_i,
    input  wire logic [3:0]                        len_i,
    // character stream out
    output logic [7:0]                             tx_data_o,
    output logic                                   tx_valid_o,
    input  wire logic                              tx_ready_i,
    // status
    output logic                                   busy_o
);
    logic [afc_pkg::MSG_BYTES*8-1:0] buf_ff;
    logic [afc_pkg::MSG_BYTES*8-1:0] nxt_buf;
    logic [3:0]                      left_ff;
    logic [3:0]                      nxt_left;
    logic [7:0]                      data_ff;
    logic [7:0]                      nxt_data;
    logic                            valid_ff;
    logic                            nxt_valid;

    always_comb begin
        nxt_buf   = buf_ff;
        nxt_left  = left_ff;
        nxt_data  = data_ff;
        nxt_valid = valid_ff;
        if (start_i && !valid_ff) begin
            nxt_data  = msg_i[7:0];
            nxt_buf   = msg_i >> 8;
            nxt_left  = len_i - 4'h1;
            nxt_valid = 1'b1;
        end else if (valid_ff && tx_ready_i) begin
            if (left_ff == 4'h0) begin
                nxt_valid = 1'b0;
            end else begin
                nxt_data = buf_ff[7:0];
                nxt_buf  = buf_ff >> 8;
                nxt_left = left_ff - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            buf_ff   <= '0;
            left_ff  <= 4'h0;
            data_ff  <= 8'h00;
            valid_ff <= 1'b0;
        end else begin
            buf_ff   <= nxt_buf;
            left_ff  <= nxt_left;
            data_ff  <= nxt_data;
            valid_ff <= nxt_valid;
        end
    end

    assign tx_data_o  = data_ff;
    assign tx_valid_o = valid_ff;
    assign busy_o     = valid_ff;
endmodule

// [afc_flag_cmd.sv]
// auxiliary flag command handler: parses ascii frames, keeps the flag bank,
// and replies with framed acknowledgements
// assumes a character source and sink on the same clock (for example a uart)
// with valid/ready handshakes; rx_err_i marks a character with a line error
//
// Summary of operation
// - frames carry two hex address chars after delimiter
// - selector 0000 loads all flags from value
// - selector 100z writes single flag at index z
// - value field hex, four flags per character
// - carriage return 0Dh ends every frame
// - accepted write replies greater-than, address, return
// - invalid operation replies question-mark, address, return
// - syntax, line error or other address: silence
// - read frame returns states of all flags
// - read reply: greater-than, own address, hex flags
// - last hex character holds flags three to zero
// - sixteen individually addressable flags numbered 0-15
`timescale 1ns/100ps
module afc_flag_cmd (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // received characters
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_err_i,
    output logic             rx_ready_o,
    // reply characters
    output logic [7:0]       tx_data_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    // flag bank toward the logic rule engine
    output logic [15:0]      flags_o
);
    // one-hot parser states, a single bit each
    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_CODE = 7'b000_0100,
        ST_SEL  = 7'b000_1000,
        ST_VAL  = 7'b001_0000,
        ST_SKIP = 7'b010_0000,
        ST_SEND = 7'b100_0000
    } afc_state_t;

    typedef enum logic [1:0] {
        RPL_NONE = 2'b00,
        RPL_ACK  = 2'b01,
        RPL_NAK  = 2'b10,
        RPL_READ = 2'b11
    } afc_reply_t;

    afc_state_t  st_ff;
    afc_state_t  nxt_st;
    logic [3:0]  cnt_ff;
    logic [3:0]  nxt_cnt;
    logic        rd_dlm_ff;
    logic        nxt_rd_dlm;
    logic [7:0]  addr_ff;
    logic [7:0]  nxt_addr;
    logic [15:0] sel_ff;
    logic [15:0] nxt_sel;
    logic [15:0] val_ff;
    logic [15:0] nxt_val;
    logic [15:0] flags_ff;
    logic [15:0] nxt_flags;

    logic        take;
    logic        is_cr;
    logic [3:0]  nib;
    logic        is_hex;
    afc_reply_t  reply;
    logic        tx_start;
    logic [3:0]  tx_len;
    logic        tx_busy;
    logic [afc_pkg::MSG_BYTES*8-1:0] msg;

    logic        addr_hit;
    logic        wr_all;
    logic        wr_one;
    logic [4*afc_pkg::READ_DIGITS-1:0] flags_pad;
    logic [7:0]  rd_char [afc_pkg::READ_DIGITS];

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        logic [7:0] ext;
        ext = {4'h0, n};
        if (n < 4'hA) begin
            hex_char = afc_pkg::ASCII_DIGIT_BASE + ext;
        end else begin
            hex_char = afc_pkg::ASCII_ALPHA_BASE + ext;
        end
    endfunction

    afc_hex_dec u_hex_dec (
        .char_i   (rx_data_i),
        .nibble_o (nib),
        .is_hex_o (is_hex)
    );

    // no input is taken while a reply goes out, so a new frame waits
    assign rx_ready_o = (st_ff != ST_SEND);
    assign take       = rx_valid_i && rx_ready_o;
    assign is_cr      = (rx_data_i == afc_pkg::CHAR_CR);
    // only our own address is served; other modules on the line stay silent
    assign addr_hit   = (addr_ff == afc_pkg::OWN_ADDR);

    // parser
    always_comb begin
        nxt_st     = st_ff;
        nxt_cnt    = cnt_ff;
        nxt_rd_dlm = rd_dlm_ff;
        nxt_addr   = addr_ff;
        nxt_sel    = sel_ff;
        nxt_val    = val_ff;
        wr_all     = 1'b0;
        wr_one     = 1'b0;
        reply      = RPL_NONE;
        unique case (st_ff)
            ST_IDLE: begin
                if (take && !rx_err_i) begin
                    if (rx_data_i == afc_pkg::CHAR_WRITE_DLM ||
                        rx_data_i == afc_pkg::CHAR_READ_DLM) begin
                        nxt_rd_dlm = (rx_data_i == afc_pkg::CHAR_READ_DLM);
                        nxt_cnt    = 4'h0;
                        nxt_sel    = 16'h0000;
                        nxt_val    = 16'h0000;
                        nxt_st     = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (take) begin
                    if (rx_err_i || !is_hex) begin
                        nxt_st = ST_SKIP;
                    end else begin
                        nxt_addr = {addr_ff[3:0], nib};
                        nxt_cnt  = cnt_ff + 4'h1;
                        if (cnt_ff == afc_pkg::ADDR_DIGITS - 4'h1) begin
                            nxt_cnt = 4'h0;
                            nxt_st  = ST_CODE;
                        end
                    end
                end
            end
            ST_CODE: begin
                if (take) begin
                    if (rx_err_i) begin
                        nxt_st = ST_SKIP;
                    end else if (cnt_ff == 4'h0 && rx_data_i == afc_pkg::CHAR_CODE_0) begin
                        nxt_cnt = 4'h1;
                    end else if (cnt_ff == 4'h1 && rx_data_i == afc_pkg::CHAR_CODE_1) begin
                        nxt_cnt = 4'h0;
                        nxt_st  = ST_SEL;
                    end else begin
                        nxt_st = ST_SKIP;
                    end
                end
            end
            ST_SEL: begin
                if (take) begin
                    if (rx_err_i) begin
                        nxt_st = ST_SKIP;
                    end else if (is_cr && cnt_ff == 4'h0) begin
                        // bare flag code: read back the whole bank
                        nxt_st = ST_IDLE;
                        if (addr_hit) begin
                            reply  = RPL_READ;
                            nxt_st = ST_SEND;
                        end
                    end else if (!is_hex || rd_dlm_ff) begin
                        nxt_st = is_cr ? ST_IDLE : ST_SKIP;
                    end else begin
                        nxt_sel = {sel_ff[11:0], nib};
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == afc_pkg::SEL_DIGITS - 4'h1) begin
                            nxt_cnt = 4'h0;
                            nxt_st  = ST_VAL;
                        end
                    end
                end
            end
            ST_VAL: begin
                if (take) begin
                    if (rx_err_i) begin
                        nxt_st = is_cr ? ST_IDLE : ST_SKIP;
                    end else if (is_cr) begin
                        nxt_st = ST_IDLE;
                        if (cnt_ff != 4'h0 && addr_hit) begin
                            nxt_st = ST_SEND;
                            if (sel_ff == afc_pkg::SEL_ALL) begin
                                wr_all = 1'b1;
                                reply  = RPL_ACK;
                            end else if (sel_ff[15:12] == afc_pkg::SEL_SINGLE &&
                                         sel_ff[11:4] == 8'h00) begin
                                wr_one = 1'b1;
                                reply  = RPL_ACK;
                            end else begin
                                reply = RPL_NAK;
                            end
                        end
                    end else if (!is_hex || cnt_ff == afc_pkg::VAL_DIGITS_MAX) begin
                        nxt_st = ST_SKIP;
                    end else begin
                        // last four digits land in the bank, earlier ones shift out
                        nxt_val = {val_ff[11:0], nib};
                        nxt_cnt = cnt_ff + 4'h1;
                    end
                end
            end
            ST_SKIP: begin
                // discard the rest of a bad frame silently
                if (take && is_cr) begin
                    nxt_st = ST_IDLE;
                end
            end
            ST_SEND: begin
                // input stays refused until one clock after the last reply character is taken
                if (!tx_busy) begin
                    nxt_st = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff     <= ST_IDLE;
            cnt_ff    <= 4'h0;
            rd_dlm_ff <= 1'b0;
            addr_ff   <= 8'h00;
            sel_ff    <= 16'h0000;
            val_ff    <= 16'h0000;
        end else begin
            st_ff     <= nxt_st;
            cnt_ff    <= nxt_cnt;
            rd_dlm_ff <= nxt_rd_dlm;
            addr_ff   <= nxt_addr;
            sel_ff    <= nxt_sel;
            val_ff    <= nxt_val;
        end
    end

    // flag bank: a whole-bank write loads every flag, a single write only the selected one
    for (genvar g = 0; g < afc_pkg::NUM_FLAGS; g++) begin : g_flag
        logic hit;
        assign hit          = wr_one && (sel_ff[3:0] == 4'(g));
        assign nxt_flags[g] = wr_all ? val_ff[g] : (hit ? val_ff[0] : flags_ff[g]);
    end

    // flags only move on an accepted write, so a read always sees the last one
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_ff <= afc_pkg::FLAGS_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // read digits: the bank is zero padded up to the digit count, first digit highest
    assign flags_pad = {{(4*afc_pkg::READ_DIGITS-afc_pkg::NUM_FLAGS){1'b0}}, flags_ff};
    for (genvar d = 0; d < afc_pkg::READ_DIGITS; d++) begin : g_digit
        assign rd_char[d] = hex_char(flags_pad[4*(afc_pkg::READ_DIGITS-1-d) +: 4]);
    end

    // reply builder; byte 0 is sent first
    always_comb begin
        msg      = '0;
        tx_len   = afc_pkg::LEN_SHORT;
        tx_start = (reply != RPL_NONE);
        msg[7:0] = (reply == RPL_NAK) ? afc_pkg::CHAR_NAK : afc_pkg::CHAR_ACK;
        msg[15:8]  = hex_char(afc_pkg::OWN_ADDR[7:4]);
        msg[23:16] = hex_char(afc_pkg::OWN_ADDR[3:0]);
        msg[31:24] = afc_pkg::CHAR_CR;
        if (reply == RPL_READ) begin
            tx_len = afc_pkg::LEN_READ;
            // leading digits are zero, the last one holds flags 3..0
            for (int i = 0; i < afc_pkg::READ_DIGITS; i++) begin
                msg[24 + 8*i +: 8] = rd_char[i];
            end
            msg[24 + 8*afc_pkg::READ_DIGITS +: 8] = afc_pkg::CHAR_CR;
        end
    end

    afc_tx u_tx (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .start_i    (tx_start),
        .msg_i      (msg),
        .len_i      (tx_len),
        .tx_data_o  (tx_data_o),
        .tx_valid_o (tx_valid_o),
        .tx_ready_i (tx_ready_i),
        .busy_o     (tx_busy)
    );

    assign flags_o = flags_ff;
endmodule

// [afc_flag_cmd_assertions.sv]
// port-level checker for the auxiliary flag command handler
// assumes it is bound to afc_flag_cmd with every port connected by name
`timescale 1ns/100ps
module afc_flag_cmd_assertions (
    // clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    // received characters
    input wire logic [7:0]  rx_data_i,
    input wire logic        rx_valid_i,
    input wire logic        rx_err_i,
    input wire logic        rx_ready_o,
    // reply characters and flags
    input wire logic [7:0]  tx_data_o,
    input wire logic        tx_valid_o,
    input wire logic        tx_ready_i,
    input wire logic [15:0] flags_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    logic       cr_tk;
    logic       tx_hs;
    logic       head;
    logic [3:0] hs_cnt_ff;
    logic [3:0] nxt_hs_cnt;

    assign cr_tk = rx_valid_i && rx_ready_o && rx_data_i == afc_pkg::CHAR_CR;
    assign tx_hs = tx_valid_o && tx_ready_i;
    assign head  = tx_data_o == afc_pkg::CHAR_ACK || tx_data_o == afc_pkg::CHAR_NAK;

    // handshakes taken so far in the current reply
    always_comb begin
        nxt_hs_cnt = hs_cnt_ff;
        if (!tx_valid_o) begin
            nxt_hs_cnt = 4'h0;
        end else if (tx_hs) begin
            nxt_hs_cnt = hs_cnt_ff + 4'h1;
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hs_cnt_ff <= 4'h0;
        end else begin
            hs_cnt_ff <= nxt_hs_cnt;
        end
    end

    property p_busy_refuse;
        tx_valid_o |-> !rx_ready_o;
    endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("input taken while a reply is out");
    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("reply character dropped before taken");
    property p_reply_head;
        $rose(tx_valid_o) |-> head;
    endproperty
    a_reply_head: assert property (p_reply_head)
        else $error("reply does not open with ack or nak");
    property p_reply_addr;
        tx_hs && head |=> tx_valid_o && tx_data_o == 8'h30;
    endproperty
    a_reply_addr: assert property (p_reply_addr)
        else $error("address high digit wrong");
    property p_reply_addr_lo;
        tx_hs && hs_cnt_ff == 4'h1 |=> tx_valid_o && tx_data_o == 8'h31;
    endproperty
    a_reply_addr_lo: assert property (p_reply_addr_lo)
        else $error("address low digit wrong");
    property p_reply_start;
        $rose(tx_valid_o) |-> $past(cr_tk, 1) || $past(cr_tk, 2);
    endproperty
    a_reply_start: assert property (p_reply_start)
        else $error("reply without a received carriage return");
    property p_cr_end;
        tx_hs && tx_data_o == afc_pkg::CHAR_CR |=> !tx_valid_o ##1 rx_ready_o;
    endproperty
    a_cr_end: assert property (p_cr_end)
        else $error("reply continues after carriage return");
    property p_len;
        tx_hs && tx_data_o == afc_pkg::CHAR_CR |-> hs_cnt_ff == 4'h3 || hs_cnt_ff == 4'hA;
    endproperty
    a_len: assert property (p_len)
        else $error("reply length wrong");
    property p_flags_cause;
        $changed(flags_o) |-> $past(cr_tk, 1) || $past(cr_tk, 2);
    endproperty
    a_flags_cause: assert property (p_flags_cause)
        else $error("flags changed without a frame end");
endmodule

// [afc_host_model.sv]
// host side: sends framed command lines and sinks replies with random stalls
// assumes the handler samples on the rising edge; this side moves on the falling one
`timescale 1ns/100ps
module afc_host_model (
    // clock
    input  wire logic       clk_sys_i,
    // characters toward the handler
    output logic [7:0]      char_o,
    output logic            valid_o,
    output logic            err_o,
    input  wire logic       ready_i,
    // reply sink
    output logic            tx_ready_o
);
    int seed = 36;

    function automatic int rnd();
        return $random(seed);
    endfunction

    initial begin
        char_o  = 8'h00;
        valid_o = 1'b0;
        err_o   = 1'b0;
    end

    // a randomly stalling sink makes the handler hold some reply characters
    always @(negedge clk_sys_i) tx_ready_o <= (rnd() % 3 != 0);

    task automatic send(input string s, input int err_at, output bit ok);
        int   n;
        logic rdy;
        ok = 1'b1;
        for (int i = 0; i <= s.len(); i++) begin
            @(negedge clk_sys_i);
            if (rnd() % 4 == 0) begin
                // a gap: the line is released and shows another pattern, never the last char
                valid_o = 1'b0;
                err_o   = 1'b0;
                char_o  = ~char_o;
                @(negedge clk_sys_i);
            end
            char_o  = (i == s.len()) ? afc_pkg::CHAR_CR : 8'(s[i]);
            valid_o = 1'b1;
            err_o   = (i == err_at);
            n = 0;
            // ready only moves on a rising edge, so it is read half a cycle ahead of it
            do begin
                rdy = ready_i;
                @(posedge clk_sys_i);
                n++;
                if (!rdy) @(negedge clk_sys_i);
            end while (!rdy && n < 200);
            if (!rdy) ok = 1'b0;
            if (!ok) break;
        end
        @(negedge clk_sys_i);
        valid_o = 1'b0;
        err_o   = 1'b0;
        char_o  = ~char_o;
    endtask
endmodule

// [tb.sv]
// self-checking bench for the auxiliary flag command handler
// assumes the host model and checker files are compiled first
`timescale 1ns/100ps
module tb;
    typedef struct {
        string       s;
        logic [15:0] f;
    } afc_note_t;

    logic        clk_sys_i;
    logic        rst_n_i;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_err;
    logic        rx_ready;
    logic [7:0]  tx_data;
    logic        tx_valid;
    logic        tx_ready;
    logic [15:0] flags;
    afc_note_t   notes[$];
    afc_note_t   nt;
    logic [15:0] fl;
    string       got = "";
    int          err_total = 0;
    int          comparisons = 0;
    bit          hung = 1'b0;

    afc_flag_cmd dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .rx_data_i(rx_data),
        .rx_valid_i(rx_valid), .rx_err_i(rx_err), .rx_ready_o(rx_ready), .tx_data_o(tx_data),
        .tx_valid_o(tx_valid), .tx_ready_i(tx_ready), .flags_o(flags));
    afc_host_model host (.clk_sys_i(clk_sys_i), .char_o(rx_data), .valid_o(rx_valid),
        .err_o(rx_err), .ready_i(rx_ready), .tx_ready_o(tx_ready));

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic finish_test();
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // upper case hex, as the handler replies
    function automatic string hex(input logic [15:0] v);
        string s;
        logic [7:0] c;
        s = "";
        for (int i = 3; i >= 0; i--) begin
            c = {4'h0, v[i*4 +: 4]};
            s = {s, $sformatf("%c", (c < 8'h0A) ? c + 8'h30 : c + 8'h37)};
        end
        return s;
    endfunction

    // a command line: delimiter and address, the flag command code, then the fields
    function automatic string cmd(input string head, input string rest);
        return {head, $sformatf("%c%c", afc_pkg::CHAR_CODE_0, afc_pkg::CHAR_CODE_1), rest};
    endfunction

    // a stalled input ends the stimulus; the closing report then fails the run
    task automatic frame(input string txt, input string rep, input int err_at = -1);
        bit ok;
        if (hung) return;
        if (rep != "") notes.push_back('{rep, fl});
        host.send(txt, err_at, ok);
        if (!ok) begin
            err_total++;
            hung = 1'b1;
            $display("mismatch %0t input not taken", $time);
        end
    endtask

    // reply watcher: pairs each finished reply with the oldest note
    always @(posedge clk_sys_i) begin
        if (rst_n_i && tx_valid && tx_ready) begin
            if (tx_data !== afc_pkg::CHAR_CR) begin
                got = {got, $sformatf("%c", tx_data)};
            end else begin
                nt = '{"(none)", 16'h0000};
                if (notes.size() > 0) nt = notes.pop_front();
                comparisons++;
                if (got != nt.s || flags !== nt.f) begin
                    err_total++;
                    $display("mismatch %0t reply %s flags %h", $time, got, flags);
                end
                got = "";
            end
        end
    end

    initial begin
        int    v;
        string s;
        rst_n_i = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        fl = afc_pkg::FLAGS_RST;
        frame(cmd("$01", ""), {">01000", hex(fl)});
        fl = 16'h002B;
        frame(cmd("#01", $sformatf("00000000%h", fl)), ">01");
        frame(cmd("$01", ""), ">01000002B");
        for (int i = 0; i < 16; i++) begin
            v = host.rnd();
            fl[i] = v[0];
            s = $sformatf("100%h000000%0d", i[3:0], v[0]);
            frame(cmd("#01", s), ">01");
        end
        frame(cmd("$01", ""), {">01000", hex(fl)});
        frame(cmd("#01", "2000000F"), "?01");
        frame(cmd("#02", "0000FFFF"), "");
        frame(cmd("#01", "0000FFFF"), "", 7);
        frame(cmd("#01", "0000G"), "");
        frame(cmd("$01", "0000FFFF"), "");
        frame(cmd("#01", "0000123456789"), "");
        frame({"x", cmd("#01", "")}, {">01000", hex(fl)});
        v = host.rnd();
        fl = v[15:0];
        frame(cmd("#01", {"0000", hex(fl)}), ">01");
        frame(cmd("$01", ""), {">01000", hex(fl)});
        for (int n = 0; n < 400 && notes.size() > 0; n++) @(posedge clk_sys_i);
        if (notes.size() > 0) begin
            err_total++;
            $display("mismatch %0t missing replies", $time);
        end
        finish_test();
    end
endmodule

bind afc_flag_cmd afc_flag_cmd_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_err_i(rx_err_i),
    .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
    .tx_ready_i(tx_ready_i), .flags_o(flags_o));
